// [rtl/xps_dev.sv]
/*
 * Crosspoint device end: serial target, command decode, 8x8 switch state
 * with latch and apply stages, and readback status.
 * Assumes the controller drives the link clock and the reset pin; both
 * arrive asynchronously and are synchronised to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module xps_dev (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Serial link
   xps_link_if.dev link,
   // Switch array state
   output logic [xps_pkg::SW_N-1:0] switchOn,
   output logic [7:0] rbStatus
);
   import xps_pkg::*;

   typedef enum logic [2:0] {
      XPS_IDLE = 3'h0,
      XPS_ADDR = 3'h1,
      XPS_AACK = 3'h3,
      XPS_WBYTE = 3'h2,
      XPS_WACK = 3'h6,
      XPS_RBYTE = 3'h7,
      XPS_RACK = 3'h5,
      XPS_SKIP = 3'h4
   } xps_dst_t;

   // Readback select recognition
   function automatic logic isReadback(input logic [7:0] b);
      isReadback = (b & RB_MASK) == RB_VALUE;
   endfunction : isReadback

   // X select code to line index; bit 3 of result marks a valid code
   function automatic logic [3:0] xDecode(input logic [3:0] c);
      unique case (c)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: xDecode = {1'b1, c[2:0]};
         4'h8: xDecode = 4'hE;
         4'h9: xDecode = 4'hF;
         default: xDecode = 4'h0;
      endcase
   endfunction : xDecode

   logic sclMeta, sclS, sclP;
   logic sdaMeta, sdaS, sdaP;
   logic rstMeta, rstS;
   xps_dst_t stQ;
   logic [3:0] cntQ;
   logic [7:0] shQ;
   logic [7:0] txQ;
   logic [7:0] hiQ;
   logic [1:0] byteQ;
   logic rwQ;
   logic oeQ;
   logic mAckQ;
   logic cmdVldQ;
   logic [15:0] cmdQ;
   logic [SW_N-1:0] pendQ;
   logic [SW_N-1:0] pendD;
   logic [SW_N-1:0] swQ;
   logic [7:0] statQ;

   // Pins from the far side pass two flops before use
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {sclP, sclS, sclMeta} <= 3'h7;
         {sdaP, sdaS, sdaMeta} <= 3'h7;
         {rstS, rstMeta} <= 2'h3;
      end else begin
         {sclP, sclS, sclMeta} <= {sclS, sclMeta, link.scl};
         {sdaP, sdaS, sdaMeta} <= {sdaS, sdaMeta, link.sda};
         {rstS, rstMeta} <= {rstMeta, link.xrstN};
      end
   end

   // Link events seen on the synchronised copies
   wire sclRise = sclS & ~sclP;
   wire sclFall = ~sclS & sclP;
   wire startSeen = sclS & sclP & sdaP & ~sdaS;
   wire stopSeen = sclS & sclP & ~sdaP & sdaS;
   wire addrHit = shQ[7:1] == DEV_ADDR;
   wire [7:0] shIn = {shQ[6:0], sdaS};
   wire [7:0] rdByte1 = statQ;

   // Serial target; data changes only after a clock fall is seen
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stQ <= XPS_IDLE;
         cntQ <= 4'h0;
         shQ <= 8'h00;
         txQ <= 8'h00;
         hiQ <= 8'h00;
         byteQ <= 2'h0;
         rwQ <= 1'b0;
         oeQ <= 1'b0;
         mAckQ <= 1'b0;
         cmdVldQ <= 1'b0;
         cmdQ <= 16'h0000;
      end else begin
         cmdVldQ <= 1'b0;
         if (startSeen) begin
            stQ <= XPS_ADDR; // R1
            cntQ <= 4'h0;
            byteQ <= 2'h0;
            oeQ <= 1'b0;
         end else if (stopSeen) begin
            stQ <= XPS_IDLE;
            oeQ <= 1'b0;
         end else begin
            unique case (stQ)
               XPS_IDLE, XPS_SKIP: oeQ <= 1'b0;
               XPS_ADDR, XPS_WBYTE: begin
                  if (sclRise && cntQ != 4'h8) begin
                     shQ <= shIn;
                     cntQ <= cntQ + 4'h1;
                  end else if (sclFall && cntQ == 4'h8) begin
                     cntQ <= 4'h0;
                     if (stQ == XPS_ADDR) begin
                        rwQ <= shQ[0];
                        stQ <= addrHit ? XPS_AACK : XPS_SKIP;
                        oeQ <= addrHit; // R2
                     end else if (byteQ == 2'h0) begin
                        hiQ <= shQ;
                        byteQ <= 2'h1;
                        stQ <= XPS_WACK;
                        oeQ <= 1'b1;
                     end else if (byteQ == 2'h1) begin
                        cmdQ <= {hiQ, shQ}; // R3
                        cmdVldQ <= rstS; // R16
                        byteQ <= 2'h2;
                        stQ <= XPS_WACK;
                        oeQ <= 1'b1;
                     end else begin
                        stQ <= XPS_SKIP; // Third byte is refused
                     end
                  end
               end
               XPS_AACK: begin
                  if (sclFall) begin
                     if (rwQ) begin
                        stQ <= XPS_RBYTE; // R8
                        txQ <= 8'h00; // R9
                        oeQ <= 1'b1;
                     end else begin
                        stQ <= XPS_WBYTE;
                        oeQ <= 1'b0;
                     end
                  end
               end
               XPS_WACK: begin
                  if (sclFall) begin
                     stQ <= XPS_WBYTE;
                     oeQ <= 1'b0;
                  end
               end
               XPS_RBYTE: begin
                  if (sclRise) begin
                     cntQ <= cntQ + 4'h1;
                  end else if (sclFall) begin
                     if (cntQ == 4'h8) begin
                        cntQ <= 4'h0;
                        stQ <= XPS_RACK;
                        oeQ <= 1'b0;
                     end else begin
                        txQ <= {txQ[6:0], 1'b0};
                        oeQ <= ~txQ[6];
                     end
                  end
               end
               XPS_RACK: begin
                  if (sclRise) begin
                     mAckQ <= ~sdaS;
                  end else if (sclFall) begin
                     if (mAckQ) begin
                        stQ <= XPS_RBYTE;
                        byteQ <= byteQ + 2'h1;
                        // Second byte carries the status, later ones zero
                        txQ <= (byteQ == 2'h0) ? rdByte1 : 8'h00; // R10
                        oeQ <= (byteQ == 2'h0) ? ~rdByte1[7] : 1'b1;
                     end else begin
                        stQ <= XPS_SKIP;
                     end
                  end
               end
               default: stQ <= XPS_IDLE;
            endcase
            // First data bit of a read is driven on entry
            if (stQ == XPS_AACK && sclFall && rwQ) begin
               oeQ <= 1'b1;
            end
         end
      end
   end

   // Command decode
   wire [3:0] xDec = xDecode(cmdQ[CW_X_HI:CW_X_LO]); // R15
   wire [2:0] ySel = cmdQ[CW_Y_HI:CW_Y_LO]; // R13
   wire cmdRb = isReadback(cmdQ[15:8]); // R11
   wire [2:0] rbX = {cmdQ[8 + RB_X2], cmdQ[8 + RB_X1], cmdQ[8 + RB_X0]};
   wire [7:0] rbRow = swQ[{rbX, 3'h0} +: 8]; // R12

   // Only the addressed latch bit changes; the rest hold
   always_comb begin
      pendD = pendQ;
      if (cmdVldQ && !cmdRb && xDec[3]) begin
         pendD[{xDec[2:0], ySel}] = cmdQ[CW_STATE]; // R4
      end
   end

   // Latch stage, switch stage and readback holding register
   always_ff @(posedge mclk) begin
      if (!rst_n || !rstS) begin
         pendQ <= 64'h0;
         swQ <= 64'h0;
         statQ <= 8'h00;
      end else if (cmdVldQ) begin
         pendQ <= pendD;
         if (cmdRb) begin
            statQ <= rbRow; // R5 R7
         end else if (cmdQ[CW_APPLY]) begin
            swQ <= pendD; // R14
         end
      end
   end

   // Outputs from flops; data pin is open drain, drives only low
   assign switchOn = swQ;
   assign rbStatus = statQ;
   assign link.devSdaOe = oeQ;
   assign link.devSdaOut = 1'b0;
endmodule : xps_dev
`default_nettype wire

// [rtl/xps_pkg.sv]
/*
 * Shared constants for the crosspoint serial command link: device bus
 * address, command word fields, readback select code, link timing and
 * the controller's register map.
 * Assumes a 40 MHz mclk on both ends.
 */
// Overview of operation
// [R1] Controller opens each transfer with address and direction
// [R2] Device pulls data low to acknowledge own address
// [R3] Write carries two bytes, one 16-bit command
// [R4] Write changes only the one selected switch
// [R5] Any switch readable through select then read
// [R6] Select write: readback code then don't-care byte
// [R7] Select copies chosen X line into status
// [R8] Read step addresses device with direction one
// [R9] Read returns two bytes, first all zeros
// [R10] Second byte: one per Y, one closed
// [R11] Select byte fixed bits and scrambled X index
// [R12] Status bit n is Y line n
// [R13] Word: state, X select, Y select, ignored bits
// [R14] Apply flag set applies latched settings
// [R15] X codes 0-5, 8, 9 valid; others reserved
// [R16] Controller holds reset high during writes
package xps_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h70;
   localparam int SW_N = 64;
   // Command word fields
   localparam int CW_STATE = 15;
   localparam int CW_X_HI = 14;
   localparam int CW_X_LO = 11;
   localparam int CW_Y_HI = 10;
   localparam int CW_Y_LO = 8;
   localparam int CW_APPLY = 0;
   // Readback select byte: mask and value of the fixed bits
   localparam logic [7:0] RB_MASK = 8'hB6;
   localparam logic [7:0] RB_VALUE = 8'h34;
   localparam int RB_X0 = 3;
   localparam int RB_X1 = 6;
   localparam int RB_X2 = 0;
   // Link timing
   localparam int MCLK_NS = 25;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QTR_CYC = SCL_PERIOD_NS / (4 * MCLK_NS);
   // Controller registers (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0C;
   localparam int CTRL_GO_WR = 0;
   localparam int CTRL_GO_RD = 1;
   localparam int CTRL_HOLD_RST = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_NACK = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   localparam logic [15:0] CMD_RESET = 16'h0;
endpackage : xps_pkg

// [rtl/xps_link_if.sv]
/*
 * Two-wire link between controller and crosspoint device.
 * Assumes an external pull-up on the data wire, modelled here.
 */
`timescale 1ns/10ps
`default_nettype none
interface xps_link_if;
   logic scl;
   logic xrstN;
   logic ctlSdaOut;
   logic ctlSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   logic sda;
   // Wired-and with pull-up: low when any enabled driver drives low
   assign sda = ~((ctlSdaOe & ~ctlSdaOut) | (devSdaOe & ~devSdaOut));
   modport ctl (output scl, xrstN, ctlSdaOut, ctlSdaOe, input sda);
   modport dev (input scl, xrstN, sda, output devSdaOut, devSdaOe);
endinterface : xps_link_if
`default_nettype wire

// [rtl/xps_ctl.sv]
/*
 * Controller end: APB register slave and two-wire master that sends one
 * 16-bit command or reads two bytes back from the crosspoint device.
 * Assumes a pull-up on the data wire and a 40 MHz mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module xps_ctl (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link
   xps_link_if.ctl link
);
   import xps_pkg::*;

   typedef enum logic [1:0] {
      XPS_CIDLE = 2'h0,
      XPS_CSTART = 2'h1,
      XPS_CBIT = 2'h3,
      XPS_CSTOP = 2'h2
   } xps_cst_t;

   xps_cst_t stQ;
   logic [1:0] phQ;
   logic [7:0] tickQ;
   logic [3:0] bitQ;
   logic [1:0] byteQ;
   logic [7:0] txQ;
   logic [7:0] rxQ;
   logic rdModeQ;
   logic nackQ;
   logic sclQ;
   logic oeQ;
   logic holdRstQ;
   logic xrstNQ;
   logic [15:0] cmdQ;
   logic [15:0] rdQ;
   logic sdaMeta, sdaS;
   logic readyQ;
   logic errQ;
   logic [31:0] rdataQ;

   // APB decode
   wire busy = stQ != XPS_CIDLE;
   wire setup = psel & penable & ~readyQ;
   wire commit = psel & penable & readyQ;
   wire hitCtrl = paddr == REG_CTRL;
   wire hitCmd = paddr == REG_CMD;
   wire hitStat = paddr == REG_STAT;
   wire hitRd = paddr == REG_RDATA;
   wire hitAny = hitCtrl | hitCmd | hitStat | hitRd;
   wire [31:0] ctrlView = {29'h0, holdRstQ, 2'h0};
   wire [31:0] statView = {30'h0, nackQ, busy};
   wire [31:0] rdMux = hitCtrl ? ctrlView : hitCmd ? {16'h0, cmdQ} :
                       hitStat ? statView : hitRd ? {16'h0, rdQ} : 32'h0;
   // No frame starts with the reset pin held: a write needs it high
   wire goOk = commit & pwrite & hitCtrl & ~busy & ~pwdata[CTRL_HOLD_RST];
   wire goWr = goOk & pwdata[CTRL_GO_WR]; // R16
   wire goRd = goOk & pwdata[CTRL_GO_RD] & ~pwdata[CTRL_GO_WR];
   wire tick = tickQ == 8'(QTR_CYC - 1);
   wire slaveAckSlot = ~rdModeQ | (byteQ == 2'h0);

   // One wait state on every access; unmapped addresses answer an error
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         readyQ <= 1'b0;
         errQ <= 1'b0;
         rdataQ <= 32'h0;
         holdRstQ <= CTRL_RESET[CTRL_HOLD_RST];
         xrstNQ <= ~CTRL_RESET[CTRL_HOLD_RST];
         cmdQ <= CMD_RESET;
      end else begin
         readyQ <= setup;
         errQ <= setup & ~hitAny;
         rdataQ <= setup ? rdMux : 32'h0;
         // Reset hold is refused while a transfer runs
         if (commit && pwrite && hitCtrl && !busy) begin
            holdRstQ <= pwdata[CTRL_HOLD_RST]; // R16
            xrstNQ <= ~pwdata[CTRL_HOLD_RST]; // R16
         end
         if (commit && pwrite && hitCmd) begin
            cmdQ <= pwdata[15:0];
         end
      end
   end

   // Data pin comes from outside and is synchronised first
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {sdaS, sdaMeta} <= 2'h3;
      end else begin
         {sdaS, sdaMeta} <= {sdaMeta, link.sda};
      end
   end

   // Quarter-bit enable; four quarters make one link clock period
   always_ff @(posedge mclk) begin
      if (!rst_n || !busy) begin
         tickQ <= 8'h00;
      end else begin
         tickQ <= tick ? 8'h00 : tickQ + 8'h01;
      end
   end

   // Bit engine: set data, raise clock, sample, lower clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stQ <= XPS_CIDLE;
         phQ <= 2'h0;
         bitQ <= 4'h0;
         byteQ <= 2'h0;
         txQ <= 8'h00;
         rxQ <= 8'h00;
         rdModeQ <= 1'b0;
         nackQ <= 1'b0;
         sclQ <= 1'b1;
         oeQ <= 1'b0;
         rdQ <= 16'h0;
      end else if (stQ == XPS_CIDLE) begin
         if (goWr || goRd) begin
            stQ <= XPS_CSTART;
            phQ <= 2'h0;
            rdModeQ <= goRd;
            nackQ <= 1'b0;
            txQ <= {DEV_ADDR, goRd}; // R1 R6 R8
         end
      end else if (tick) begin
         phQ <= phQ + 2'h1;
         unique case (stQ)
            XPS_CSTART: begin
               if (phQ == 2'h1) oeQ <= 1'b1;
               if (phQ == 2'h2) sclQ <= 1'b0;
               if (phQ == 2'h3) begin
                  stQ <= XPS_CBIT;
                  bitQ <= 4'h0;
                  byteQ <= 2'h0;
               end
            end
            XPS_CBIT: begin
               unique case (phQ)
                  2'h0: begin
                     if (bitQ != 4'h8) begin
                        oeQ <= slaveAckSlot & ~txQ[7];
                     end else begin
                        // Master acks the first read byte, not the last
                        oeQ <= ~slaveAckSlot & (byteQ == 2'h1);
                     end
                  end
                  2'h1: sclQ <= 1'b1;
                  2'h2: begin
                     if (bitQ != 4'h8) begin
                        rxQ <= {rxQ[6:0], sdaS};
                        txQ <= {txQ[6:0], 1'b0};
                     end else if (slaveAckSlot && sdaS) begin
                        nackQ <= 1'b1;
                     end
                  end
                  default: begin
                     sclQ <= 1'b0;
                     if (bitQ != 4'h8) begin
                        bitQ <= bitQ + 4'h1;
                     end else if (nackQ || byteQ == 2'h2) begin
                        if (rdModeQ && byteQ == 2'h2) rdQ[7:0] <= rxQ;
                        stQ <= XPS_CSTOP;
                        oeQ <= 1'b1;
                     end else begin
                        if (rdModeQ && byteQ == 2'h1) rdQ[15:8] <= rxQ;
                        bitQ <= 4'h0;
                        byteQ <= byteQ + 2'h1;
                        // Two command bytes follow the address
                        txQ <= (byteQ == 2'h0) ? cmdQ[15:8] : cmdQ[7:0];
                     end
                  end
               endcase
            end
            XPS_CSTOP: begin
               if (phQ == 2'h0) oeQ <= 1'b1;
               if (phQ == 2'h1) sclQ <= 1'b1;
               if (phQ == 2'h2) oeQ <= 1'b0;
               if (phQ == 2'h3) stQ <= XPS_CIDLE;
            end
            default: stQ <= XPS_CIDLE;
         endcase
      end
   end

   // Outputs from flops
   assign prdata = rdataQ;
   assign pready = readyQ;
   assign pslverr = errQ;
   assign link.scl = sclQ;
   assign link.ctlSdaOe = oeQ;
   assign link.ctlSdaOut = 1'b0;
   assign link.xrstN = xrstNQ;
endmodule : xps_ctl
`default_nettype wire

// [sim/xps_link_sva.sv]
/*
 * Checker for the crosspoint two-wire link.
 * Assumes the bench hands it the link wires, mclk and rst_n.
 */
`timescale 1ns/10ps
`default_nettype none
module xps_link_sva (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Link wires
   input wire logic scl,
   input wire logic xrstN,
   input wire logic ctlSdaOe,
   input wire logic devSdaOut,
   input wire logic devSdaOe,
   input wire logic sda
);
   import xps_pkg::*;
   logic sclQ, sdaQ, rwQ;
   logic [3:0] bitQ;
   logic [1:0] byteQ;
   logic [7:0] shQ;
   // A start is a data fall while the clock stays high
   wire startSeen = scl & sclQ & sdaQ & ~sda;
   wire sclRise = scl & ~sclQ;
   wire ackSlot = sclRise & (bitQ == 4'h8);
   wire isMe = shQ[7:1] == DEV_ADDR;

   // Frame tracker; the shift skips the ack bit so it holds whole bytes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
         bitQ <= 4'h0;
         byteQ <= 2'h0;
         shQ <= 8'h00;
         rwQ <= 1'b0;
      end else begin
         sclQ <= scl;
         sdaQ <= sda;
         if (startSeen) begin
            bitQ <= 4'h0;
            byteQ <= 2'h0;
         end else if (ackSlot) begin
            bitQ <= 4'h0;
            byteQ <= byteQ + 2'h1;
            if (byteQ == 2'h0) rwQ <= shQ[0];
         end else if (sclRise) begin
            bitQ <= bitQ + 4'h1;
            shQ <= {shQ[6:0], sda};
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_open_drain;
      devSdaOe |-> !devSdaOut;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("device drives data high");
   // Only the controller may move data while the clock is high
   property p_dev_stable;
      scl && $past(scl) |-> $stable(devSdaOe);
   endproperty
   a_dev_stable: assert property (p_dev_stable)
      else $error("device moved data with clock high");
   property p_quiet_addr;
      byteQ == 2'h0 && bitQ < 4'h8 |-> !devSdaOe;
   endproperty
   a_quiet_addr: assert property (p_quiet_addr)
      else $error("device drove during address byte");
   property p_addr_ack;
      ackSlot && byteQ == 2'h0 && isMe |-> devSdaOe && !sda;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acknowledged");
   property p_data_ack;
      ackSlot && !rwQ && (byteQ == 2'h1 || byteQ == 2'h2) |-> devSdaOe;
   endproperty
   a_data_ack: assert property (p_data_ack)
      else $error("write byte not acknowledged");
   property p_read_zero;
      sclRise && rwQ && byteQ == 2'h1 && bitQ < 4'h8 |-> !sda;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("first read byte not zero");
   property p_reset_idle;
      disable iff (1'b0) !rst_n |=> scl && xrstN && !ctlSdaOe && !devSdaOe;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("link not idle in reset");
   property p_dev_reset;
      !xrstN |-> ##[0:6] !devSdaOe;
   endproperty
   a_dev_reset: assert property (p_dev_reset)
      else $error("device still drives under reset pin");
   // While the device reset pin is held the link stays idle
   property p_hold_idle;
      !xrstN |-> scl && !ctlSdaOe;
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("link active with device reset held");
endmodule : xps_link_sva
`default_nettype wire

// [sim/xps_tb.sv]
/*
 * Bench: controller and device joined by the link interface, driven
 * over APB. Assumes the package link timing (about 12k mclk a frame).
 */
`timescale 1ns/10ps
`default_nettype none
module xps_tb;
   import xps_pkg::*;
   localparam int CYC_MAX = 95000;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
   logic [7:0] paddr, rbStatus;
   logic [31:0] pwdata, prdata, rdVal;
   logic [SW_N-1:0] switchOn;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;

   xps_link_if link ();
   xps_ctl i_xps_ctl (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   xps_dev i_xps_dev (.mclk(mclk), .rst_n(rst_n), .link(link),
      .switchOn(switchOn), .rbStatus(rbStatus));
   xps_link_sva i_xps_link_sva (.mclk(mclk), .rst_n(rst_n),
      .scl(link.scl), .xrstN(link.xrstN), .ctlSdaOe(link.ctlSdaOe),
      .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe),
      .sda(link.sda));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Hang guard, sized for six link frames
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == CYC_MAX) begin
         n_fail++;
         $display("mismatch timeout expected end seen hang");
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic chkWord(input string what, input logic [31:0] e,
         input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chkWord

   task automatic chkSw(input string what, input logic [63:0] e,
         input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chkSw

   // One APB transfer; waits as long as the slave holds pready low
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdVal = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
         input string what);
      apb(1'b0, a, 32'h0000_0000);
      chkWord(what, e, rdVal);
   endtask : rdChk

   // Load a command, start a frame, poll busy; nack must stay clear
   task automatic run(input logic [15:0] cmd, input logic [31:0] go);
      apb(1'b1, REG_CMD, {16'h0000, cmd});
      apb(1'b1, REG_CTRL, go);
      rdVal = 32'h0000_0001;
      while (rdVal[STAT_BUSY] !== 1'b0) apb(1'b0, REG_STAT, 32'h0);
      chkWord("stat", 32'h0000_0000, rdVal);
   endtask : run

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values and an unmapped address
      rdChk(REG_CTRL, CTRL_RESET, "ctrl");
      rdChk(REG_CMD, {16'h0000, CMD_RESET}, "cmd");
      rdChk(8'h10, 32'h0000_0000, "unmapped");
      chkWord("slverr", 32'h0000_0001, {31'h0, rdErr});
      chkSw("switches", 64'h0, switchOn);
      $display("test reset done");
      // Close X1-Y2 and apply; only that switch moves
      run(16'h8A01, 32'h0000_0001);
      rdChk(REG_CMD, 32'h0000_8A01, "cmd");
      chkSw("x1y2", 64'h0000_0000_0000_0400, switchOn);
      // Code 8 is X6, both go bits mean write; apply clear only latches
      run(16'hC700, 32'h0000_0003);
      chkSw("latched", 64'h0000_0000_0000_0400, switchOn);
      // Reserved X code with apply set releases the latched X6-Y7
      run(16'hB001, 32'h0000_0001);
      chkSw("apply", 64'h0080_0000_0000_0400, switchOn);
      // Code 9 is X7
      run(16'hCF01, 32'h0000_0001);
      chkSw("x7", 64'h8080_0000_0000_0400, switchOn);
      $display("test write done");
      // Select X6 for readback, then read two bytes
      run(16'h75A5, 32'h0000_0001);
      chkWord("rbstatus", 32'h0000_0080, {24'h0, rbStatus});
      chkSw("select", 64'h8080_0000_0000_0400, switchOn);
      run(16'h0000, 32'h0000_0002);
      rdChk(REG_RDATA, 32'h0000_0080, "rdata");
      $display("test readback done");
      // Hold the device reset pin low; state must clear
      apb(1'b1, REG_CTRL, 32'h0000_0004);
      repeat (10) @(posedge mclk);
      chkSw("held", 64'h0, switchOn);
      chkWord("rbheld", 32'h0, {24'h0, rbStatus});
      rdChk(REG_CTRL, 32'h0000_0004, "ctrlhold");
      // A go with the reset pin held is refused
      apb(1'b1, REG_CTRL, 32'h0000_0005);
      rdChk(REG_STAT, 32'h0000_0000, "holdgo");
      apb(1'b1, REG_CTRL, 32'h0000_0000);
      $display("test device reset done");
      results();
   end
endmodule : xps_tb
`default_nettype wire
